//--- rtl/lmds_map.svh
// constants for the line monitor diagnostic sequencer
`ifndef LMDS_MAP_SVH
`define LMDS_MAP_SVH
`define LMDS_TEST_MEM 4'h3
`define LMDS_TEST_ROM 4'h4
`define LMDS_TEST_INP 4'h5
`define LMDS_TEST_OUT 4'h6
`define LMDS_TEST_CNT 4'h7
`define LMDS_FAIL_WR 4'h1
`define LMDS_FAIL_CMP 4'h2
`define LMDS_PATTERN 8'h55
`define LMDS_SUB_LAST 4'hc
`define LMDS_SUB_BUZZ 4'ha
`define LMDS_DEB_NS 10000
`define LMDS_CLK_MHZ 50
`define LMDS_DEB_CYC ((`LMDS_DEB_NS * `LMDS_CLK_MHZ + 999) / 1000)
`define LMDS_STEP_CYC 16'h0040
`endif

//--- rtl/lmds_pkg.sv
// types for the line monitor diagnostic sequencer
package lmds_pkg;
   typedef enum logic [3:0] {
      ST_IDLE, ST_MEM_WR, ST_MEM_RD, ST_MEM_WRC, ST_MEM_RDC, ST_ROM,
      ST_INP, ST_OUT, ST_CNT, ST_DONE
   } lmds_state_e;
   // seven display digits, a to f then g
   typedef struct packed {
      logic [3:0] g;
      logic [3:0] f;
      logic [3:0] e;
      logic [3:0] d;
      logic [3:0] c;
      logic [3:0] b;
      logic [3:0] a;
   } lmds_digits_s;
   // raw key inputs from the front panel
   typedef struct packed {
      logic hold;
      logic reset;
      logic total;
      logic indicator_check_key;
      logic self_check_key;
      logic buzzer_enable;
      logic function_up;
      logic function_down;
      logic automatic_reset;
      logic slot_select;
      logic error_buzzer;
   } lmds_keys_s;
   // alarm lines sampled by the input test
   typedef struct packed {
      logic multiframe_alarm;
      logic far_end_alarm;
      logic far_end_multiframe_alarm;
      logic signal_loss;
      logic all_ones_alarm;
      logic alignment_loss;
   } lmds_alarms_s;
endpackage

//--- rtl/lmds_ram.sv
// working memory under test, registered read data
`timescale 1ns/1ps
`default_nettype none
module lmds_ram #(
   parameter int AW = 6
) (
   // clock
   input wire logic sys_clk,
   input wire logic ce,
   // port
   input wire logic we,
   input wire logic [AW-1:0] addr,
   input wire logic [7:0] wdata,
   output logic [7:0] rdata
);
   logic [7:0] mem [0:(1<<AW)-1];
   // read data is registered
   always_ff @(posedge sys_clk) begin
      if (ce) begin
         if (we) begin
            mem[addr] <= wdata;
         end
         rdata <= mem[addr];
      end
   end
endmodule
`default_nettype wire

//--- rtl/lmds_debounce.sv
// two-stage synchroniser plus stable-count debounce for one key
`timescale 1ns/1ps
`default_nettype none
module lmds_debounce #(
   parameter int CYC = 500
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic ce,
   // key
   input wire logic raw,
   output logic clean
);
   typedef struct packed {
      logic s1;
      logic s2;
      logic [15:0] cnt;
      logic out;
   } lmds_deb_s;
   lmds_deb_s q, d;
   initial begin
      if (CYC < 1 || CYC > 65535) begin
         $error("debounce count out of range");
      end
   end
   // s1 is read only by s2
   always_comb begin
      d = q;
      d.s1 = raw;
      d.s2 = q.s1;
      if (q.s2 == q.out) begin
         d.cnt = 16'h0000;
      end else if (q.cnt == 16'(CYC - 1)) begin
         d.cnt = 16'h0000;
         d.out = q.s2;
      end else begin
         d.cnt = q.cnt + 16'h0001;
      end
   end
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         q <= '0;
      end else if (ce) begin
         q <= d;
      end
   end
   assign clean = q.out;
endmodule
`default_nettype wire

//--- rtl/lmds_top.sv
// diagnostic sequencer: memory, checksum, input, output and counter tests
// What this block does
// - memory test: pattern then complement, verified
// - digit g 3; f shows 3 pass, 1/2 fail
// - program store halves summed modulo 256
// - digit g 4; sums on a-c, d-f
// - digit g 5; digits show weighted input triples, a pair on b
// - fixed key and alarm weight map per digit
// - input test advances only on reset plus indicator
// - self check also shows weight 2 digit f
// - output sub-tests: all high, all low, walking one
// - digit g 6; e,f show octal sub-test
// - hold freezes sub-test; leaves after 13 sub-tests
// - buzzer on in sub-tests 00 and 12
// - counter chain counts pulses; strobe latches, clears
// - digit g 7; total on c-f after slot key
// - three-digit output multiplexed, active-low selects
// - counter test repeats without leaving
// - tests run ascending, stop after 7
// - hold key keeps current test, except the input test
`timescale 1ns/1ps
`default_nettype none
`include "lmds_map.svh"
module lmds_top #(
   parameter int RAM_AW = 6,
   parameter int ROM_AW = 8,
   parameter int DEB_CYC = `LMDS_DEB_CYC
) (
   // clock, reset, enable
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic ce,
   // operator interface
   input wire logic start,
   input wire lmds_pkg::lmds_keys_s keys,
   input wire lmds_pkg::lmds_alarms_s alarms,
   // program store read port
   output logic [ROM_AW-1:0] rom_addr,
   input wire logic [7:0] rom_data,
   // tester pulses
   input wire logic count_pulse,
   input wire logic latch_strobe,
   // display and outputs
   output lmds_pkg::lmds_digits_s digits,
   output logic [2:0] port_c_lines,
   output logic [7:0] port_a_lines,
   output logic buzzer,
   output logic [3:0] mux_digit,
   output logic [2:0] mux_sel_n,
   output logic test_done
);
   localparam int NK = $bits(lmds_pkg::lmds_keys_s);
   initial begin
      if (RAM_AW < 2 || RAM_AW > 12 || ROM_AW < 2 || ROM_AW > 16) begin
         $error("address width out of range");
      end
   end

   // debounced keys
   logic [NK-1:0] key_raw, key_deb;
   lmds_pkg::lmds_keys_s k;
   assign key_raw = keys;
   genvar gi;
   generate
      for (gi = 0; gi < NK; gi++) begin : g_deb
         lmds_debounce #(.CYC(DEB_CYC)) u_deb (
            .sys_clk(sys_clk),
            .rst_n(rst_n),
            .ce(ce),
            .raw(key_raw[gi]),
            .clean(key_deb[gi])
         );
      end
   endgenerate
   assign k = key_deb;

   typedef struct packed {
      lmds_pkg::lmds_state_e st;
      logic [1:0] pin_s1;       // pulse/strobe synchroniser stage 1
      logic [1:0] pin_s2;
      logic [1:0] pin_s3;       // edge reference
      logic [5:0] alm_s1;
      logic [5:0] alm_s2;
      logic start_s1;
      logic start_s2;
      logic [RAM_AW-1:0] ra;
      logic ram_we;
      logic [7:0] ram_wd;
      logic chk_v;              // compare pending
      logic [3:0] fail;
      logic [ROM_AW-1:0] rom_a;
      logic rom_v;
      logic [7:0] sum1;
      logic [7:0] sum2;
      logic [15:0] step;
      logic [3:0] sub;
      logic adv_lock;           // wait for reset+indicator release
      logic [3:0] cnt0;
      logic [3:0] cnt1;
      logic [3:0] cnt2;
      logic [3:0] cnt3;
      logic [15:0] latched;
      logic [1:0] mux_ph;
      lmds_pkg::lmds_digits_s dig;
      logic [2:0] pc;
      logic [7:0] pa;
      logic buzz;
      logic [3:0] mxd;
      logic [2:0] mxs_n;
      logic done;
   } lmds_state_s;
   lmds_state_s q, d;
   logic [7:0] ram_rd;

   lmds_ram #(.AW(RAM_AW)) u_ram (
      .sys_clk(sys_clk),
      .ce(ce),
      .we(q.ram_we),
      .addr(q.ra),
      .wdata(q.ram_wd),
      .rdata(ram_rd)
   );

   // 8-bit value to three digits of 4 bits, octal-style nibble split
   function automatic logic [11:0] split3(input logic [7:0] v);
      split3 = {2'b00, v[7:6], 1'b0, v[5:3], 1'b0, v[2:0]};
   endfunction

   always_comb begin
      logic pulse_edge;
      logic strobe_edge;
      logic last_ra;
      logic step_due;
      lmds_pkg::lmds_alarms_s al;
      pulse_edge = 1'b0;
      strobe_edge = 1'b0;
      last_ra = 1'b0;
      step_due = 1'b0;
      al = '0;
      d = q;
      d.pin_s1 = {latch_strobe, count_pulse};
      d.pin_s2 = q.pin_s1;
      d.pin_s3 = q.pin_s2;
      d.alm_s1 = alarms;
      d.alm_s2 = q.alm_s1;
      d.start_s1 = start;
      d.start_s2 = q.start_s1;
      al = q.alm_s2;
      pulse_edge = q.pin_s2[0] & ~q.pin_s3[0];
      strobe_edge = q.pin_s2[1] & ~q.pin_s3[1];
      last_ra = (q.ra == {RAM_AW{1'b1}});
      step_due = (q.step == `LMDS_STEP_CYC);
      d.ram_we = 1'b0;
      d.chk_v = 1'b0;
      d.buzz = 1'b0;
      d.step = step_due ? 16'h0000 : q.step + 16'h0001;
      case (q.st)
         lmds_pkg::ST_IDLE: begin
            d.dig = '0;
            if (q.start_s2) begin
               d.st = lmds_pkg::ST_MEM_WR;
               d.ra = '0;
               d.fail = 4'h0;
               d.done = 1'b0;
            end
         end
         // pattern pass then complement pass
         lmds_pkg::ST_MEM_WR, lmds_pkg::ST_MEM_WRC: begin
            d.dig.g = `LMDS_TEST_MEM;
            d.ram_we = 1'b1;
            d.ram_wd = (q.st == lmds_pkg::ST_MEM_WR) ? `LMDS_PATTERN : ~`LMDS_PATTERN;
            if (q.ram_we) begin
               d.ra = q.ra + 1'b1;
               if (last_ra) begin
                  d.ram_we = 1'b0;
                  d.ra = '0;
                  d.st = (q.st == lmds_pkg::ST_MEM_WR) ? lmds_pkg::ST_MEM_RD
                                                       : lmds_pkg::ST_MEM_RDC;
               end
            end
         end
         lmds_pkg::ST_MEM_RD, lmds_pkg::ST_MEM_RDC: begin
            d.dig.g = `LMDS_TEST_MEM;
            // compare read data one cycle after its address
            d.chk_v = ~q.chk_v;
            if (q.chk_v) begin
               if (ram_rd != q.ram_wd && q.fail == 4'h0) begin
                  d.fail = (q.st == lmds_pkg::ST_MEM_RD) ? `LMDS_FAIL_WR
                                                         : `LMDS_FAIL_CMP;
               end
               d.ra = q.ra + 1'b1;
               if (last_ra) begin
                  d.ra = '0;
                  if (q.st == lmds_pkg::ST_MEM_RD) begin
                     d.st = lmds_pkg::ST_MEM_WRC;
                  end else begin
                     // result shows at once, so a held test can still be read
                     d.dig.f = (d.fail == 4'h0) ? `LMDS_TEST_MEM : d.fail;
                     if (!k.hold) begin
                        d.st = lmds_pkg::ST_ROM;
                        d.rom_a = '0;
                        d.rom_v = 1'b0;
                        d.sum1 = 8'h00;
                        d.sum2 = 8'h00;
                     end else begin
                        d.ra = q.ra;
                        d.chk_v = 1'b1;
                     end
                  end
               end
            end
         end
         lmds_pkg::ST_ROM: begin
            d.dig.g = `LMDS_TEST_ROM;
            if (!q.rom_v) begin
               // store answers within the cycle: rom_data is the byte at rom_a
               if (q.rom_a[ROM_AW-1]) begin
                  d.sum2 = q.sum2 + rom_data;
               end else begin
                  d.sum1 = q.sum1 + rom_data;
               end
               // stop on the last address so no byte is summed twice
               if (q.rom_a == {ROM_AW{1'b1}}) begin
                  d.rom_v = 1'b1;
               end else begin
                  d.rom_a = q.rom_a + 1'b1;
               end
            end else begin
               d.dig[11:0] = split3(q.sum1);
               d.dig[23:12] = split3(q.sum2);
               if (!k.hold) begin
                  d.st = lmds_pkg::ST_INP;
                  d.adv_lock = 1'b1;
               end
            end
         end
         lmds_pkg::ST_INP: begin
            if (step_due) begin
               d.dig.g = `LMDS_TEST_INP;
               d.dig.a = {1'b0, k.total, k.reset, k.hold};
               d.dig.b = {2'b00, k.self_check_key, k.indicator_check_key};
               d.dig.c = {1'b0, k.function_down, k.function_up, k.buzzer_enable};
               d.dig.d = {1'b0, k.error_buzzer, k.slot_select, k.automatic_reset};
               d.dig.e = {1'b0, al.far_end_multiframe_alarm, al.far_end_alarm,
                          al.multiframe_alarm};
               d.dig.f = {1'b0, al.alignment_loss,
                          al.all_ones_alarm | k.self_check_key, al.signal_loss};
            end
            // one advance per press of the pair
            if (!(k.reset && k.indicator_check_key)) begin
               d.adv_lock = 1'b0;
            end else if (!q.adv_lock) begin
               d.st = lmds_pkg::ST_OUT;
               d.sub = 4'h0;
               d.step = 16'h0000;
            end
         end
         lmds_pkg::ST_OUT: begin
            d.dig = '0;
            d.dig.g = `LMDS_TEST_OUT;
            d.dig.e = {3'b000, q.sub[3]};
            d.dig.f = {1'b0, q.sub[2:0]};
            d.pc = 3'b000;
            d.pa = 8'h00;
            if (q.sub == 4'h0) begin
               d.pc = 3'b111;
               d.pa = 8'hff;
            end else if (q.sub >= 4'h2 && q.sub <= 4'h4) begin
               d.pc = 3'(3'b001 << (q.sub - 4'h2));
            end else if (q.sub >= 4'h5) begin
               d.pa = 8'(8'h01 << (q.sub - 4'h5));
            end
            d.buzz = (q.sub == 4'h0) || (q.sub == `LMDS_SUB_BUZZ);
            if (step_due && !k.hold) begin
               if (q.sub == `LMDS_SUB_LAST) begin
                  d.st = lmds_pkg::ST_CNT;
                  d.dig.g = `LMDS_TEST_CNT; // lines clear with digit g, never under a 6
                  d.pc = 3'b000;
                  d.pa = 8'h00;
                  d.buzz = 1'b0;
                  {d.cnt3, d.cnt2, d.cnt1, d.cnt0} = 16'h0000;
                  d.latched = 16'h0000;
               end else begin
                  d.sub = q.sub + 4'h1;
               end
            end
         end
         lmds_pkg::ST_CNT: begin
            d.dig.g = `LMDS_TEST_CNT;
            if (strobe_edge) begin
               d.latched = {q.cnt3, q.cnt2, q.cnt1, q.cnt0};
               {d.cnt3, d.cnt2, d.cnt1, d.cnt0} = 16'h0000;
            end else if (pulse_edge) begin
               // decade chain, wraps at 9999
               d.cnt0 = (q.cnt0 == 4'h9) ? 4'h0 : q.cnt0 + 4'h1;
               if (q.cnt0 == 4'h9) begin
                  d.cnt1 = (q.cnt1 == 4'h9) ? 4'h0 : q.cnt1 + 4'h1;
                  if (q.cnt1 == 4'h9) begin
                     d.cnt2 = (q.cnt2 == 4'h9) ? 4'h0 : q.cnt2 + 4'h1;
                     if (q.cnt2 == 4'h9) begin
                        d.cnt3 = (q.cnt3 == 4'h9) ? 4'h0 : q.cnt3 + 4'h1;
                     end
                  end
               end
            end
            if (k.slot_select) begin
               d.dig.c = q.latched[15:12];
               d.dig.d = q.latched[11:8];
               d.dig.e = q.latched[7:4];
               d.dig.f = q.latched[3:0];
            end
            d.done = 1'b1;
            if (k.reset && !k.hold) begin
               d.st = lmds_pkg::ST_DONE;
            end
         end
         lmds_pkg::ST_DONE: begin
            d.done = 1'b1;
            d.dig = '0;
            if (q.start_s2) begin
               d.st = lmds_pkg::ST_IDLE;
            end
         end
         default: begin
            d.st = lmds_pkg::ST_IDLE;
         end
      endcase
      // three upper decades multiplexed, one select low at a time
      if (step_due) begin
         d.mux_ph = (q.mux_ph == 2'd2) ? 2'd0 : q.mux_ph + 2'd1;
      end
      case (q.mux_ph)
         2'd0: begin
            d.mxd = q.latched[7:4];
            d.mxs_n = 3'b110;
         end
         2'd1: begin
            d.mxd = q.latched[11:8];
            d.mxs_n = 3'b101;
         end
         default: begin
            d.mxd = q.latched[15:12];
            d.mxs_n = 3'b011;
         end
      endcase
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         q <= '0;
         q.st <= lmds_pkg::ST_IDLE;
         q.mxs_n <= 3'b111;
      end else if (ce) begin
         q <= d;
      end
   end

   // outputs straight from flip-flops
   assign rom_addr = q.rom_a;
   assign digits = q.dig;
   assign port_c_lines = q.pc;
   assign port_a_lines = q.pa;
   assign buzzer = q.buzz;
   assign mux_digit = q.mxd;
   assign mux_sel_n = q.mxs_n;
   assign test_done = q.done;
endmodule
`default_nettype wire

//--- sim/lmds_panel_model.sv
// front panel keys, program store and logic pulser facing the sequencer
`timescale 1ns/1ps
`default_nettype none
module lmds_panel_model (
   // clock
   input wire logic sys_clk,
   // program store
   input wire logic [7:0] rom_addr,
   output logic [7:0] rom_data,
   // keys and alarm lines
   output var lmds_pkg::lmds_keys_s keys,
   output var lmds_pkg::lmds_alarms_s alarms,
   // pulser
   output var logic count_pulse,
   output var logic latch_strobe
);
   // store contents: an arbitrary spread; both half sums come out equal
   function automatic logic [7:0] rom_byte(input logic [7:0] a);
      return a * 8'h25 + 8'h11;
   endfunction

   // combinational store, sampled by the sequencer on the next edge
   assign rom_data = rom_byte(rom_addr);

   // panel idle at time zero
   initial begin
      keys = '0;
      alarms = '0;
      count_pulse = 1'b0;
      latch_strobe = 1'b0;
   end

   // operator keys and alarm levels, changed off the sampling edge
   task automatic set_panel(input logic [10:0] k, input logic [5:0] a);
      @(negedge sys_clk);
      keys = k;
      alarms = a;
   endtask

   // n pulses, four cycles high and four low so none is missed
   task automatic pulses(input int n);
      repeat (n) begin
         @(negedge sys_clk);
         count_pulse = 1'b1;
         repeat (4) @(negedge sys_clk);
         count_pulse = 1'b0;
         repeat (3) @(negedge sys_clk);
      end
   endtask

   // single latch-and-clear pulse from the tester
   task automatic strobe();
      @(negedge sys_clk);
      latch_strobe = 1'b1;
      repeat (4) @(negedge sys_clk);
      latch_strobe = 1'b0;
      repeat (4) @(negedge sys_clk);
   endtask
endmodule
`default_nettype wire

//--- sim/lmds_top_props.sv
// concurrent checks on the diagnostic sequencer ports
`timescale 1ns/1ps
`default_nettype none
module lmds_top_props #(
   parameter int DEB_CYC = 500
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst_n,
   // keys
   input wire lmds_pkg::lmds_keys_s keys,
   // display and lines
   input wire lmds_pkg::lmds_digits_s digits,
   input wire logic [2:0] port_c_lines,
   input wire logic [7:0] port_a_lines,
   input wire logic buzzer,
   input wire logic [2:0] mux_sel_n,
   input wire logic test_done
);
   logic [15:0] hold_cnt_q;
   logic [4:0] sub;

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);

   // octal sub-test number shown on e and f
   assign sub = {digits.e[1:0], digits.f[2:0]};

   // cycles hold has stood high; saturates so it never wraps to zero
   always_ff @(posedge sys_clk) begin
      if (!rst_n || !keys.hold) begin
         hold_cnt_q <= 16'h0000;
      end else if (hold_cnt_q != 16'hffff) begin
         hold_cnt_q <= hold_cnt_q + 16'h0001;
      end
   end

   // lines each sub-test should raise, {port c, port a}
   function automatic logic [10:0] lines_exp(input logic [4:0] n);
      if (n == 5'h00) return 11'h7ff;
      if (n >= 5'h02 && n <= 5'h04) return {3'(1 << (n - 5'h02)), 8'h00};
      if (n >= 5'h05 && n <= 5'h0c) return {3'h0, 8'(1 << (n - 5'h05))};
      return 11'h000;
   endfunction

   AST_SEL_ONEHOT:
      assert property (mux_sel_n != 3'h7 |-> $onehot(~mux_sel_n))
      else $error("digit select not one-hot");
   AST_SEL_TURN:
      assert property ($changed(mux_sel_n) && mux_sel_n != 3'h7 && $past(mux_sel_n) != 3'h7
         |-> mux_sel_n == {$past(mux_sel_n[1:0]), $past(mux_sel_n[2])})
      else $error("digit select out of turn");
   AST_BUZZ:
      assert property ($stable(digits) [*2] ##0 digits.g == 4'h6
         |-> buzzer == (sub == 5'h00 || sub == 5'h0a))
      else $error("buzzer wrong for sub-test");
   AST_LINES:
      assert property ($stable(digits) [*2] ##0 digits.g == 4'h6
         |-> {port_c_lines, port_a_lines} == lines_exp(sub))
      else $error("output lines wrong for sub-test");
   AST_ORDER:
      assert property ($changed(digits.g) && digits.g != 4'h0
         |-> digits.g == $past(digits.g) + 4'h1 || $past(digits.g) == 4'h0)
      else $error("test number out of order");
   AST_MEM_F:
      assert property (digits.g == 4'h3 |-> digits.f <= 4'h3)
      else $error("memory result digit out of range");
   AST_HOLD:
      assert property (hold_cnt_q > DEB_CYC + 4 && digits.g inside {4'h3, 4'h4, 4'h6, 4'h7}
         |=> $stable(digits.g) && (digits.g != 4'h6 || $stable(sub)))
      else $error("test moved on while held");
   AST_DONE:
      assert property ($rose(test_done) |-> ##[0:2] digits.g == 4'h7)
      else $error("done raised outside counter test");

   COV_ROM_HELD: cover property (digits.g == 4'h4 && hold_cnt_q > DEB_CYC + 4);
   COV_SUB_LAST: cover property (digits.g == 4'h6 && sub == 5'h0c);
   COV_MUX: cover property (digits.g == 4'h7 && mux_sel_n != 3'h7);
endmodule

bind lmds_top lmds_top_props #(.DEB_CYC(DEB_CYC)) i_props (
   .sys_clk(sys_clk), .rst_n(rst_n), .keys(keys), .digits(digits),
   .port_c_lines(port_c_lines), .port_a_lines(port_a_lines), .buzzer(buzzer),
   .mux_sel_n(mux_sel_n), .test_done(test_done)
);
`default_nettype wire

//--- sim/lmds_top_tb_top.sv
// self-checking bench for the diagnostic sequencer
`timescale 1ns/1ps
`default_nettype none
module lmds_top_tb_top;
   logic sys_clk, rst_n, ce, start, count_pulse, latch_strobe, buzzer, test_done;
   logic [7:0] rom_addr, rom_data, port_a_lines, ea, s1, s2;
   logic [2:0] port_c_lines, mux_sel_n, ec;
   logic [3:0] mux_digit;
   lmds_pkg::lmds_keys_s keys;
   lmds_pkg::lmds_alarms_s alarms;
   lmds_pkg::lmds_digits_s digits;
   int n_fail = 0;
   int tests_run = 0;
   int s;
   // one weight per row on every digit that has it, then self check alone
   logic [10:0] key_tab [4] = '{11'h4a4, 11'h252, 11'h109, 11'h040};
   logic [5:0] alm_tab [4] = '{6'h24, 6'h12, 6'h09, 6'h00};
   logic [23:0] dig_tab [4] = '{24'h111111, 24'h222222, 24'h444404, 24'h200020};

   // 50 MHz clock
   initial begin
      sys_clk = 1'b0;
      forever #10 sys_clk = ~sys_clk;
   end

   // short debounce keeps key actions to a few cycles
   lmds_top #(.RAM_AW(6), .ROM_AW(8), .DEB_CYC(2)) i_dut (
      .sys_clk(sys_clk), .rst_n(rst_n), .ce(ce), .start(start), .keys(keys),
      .alarms(alarms), .rom_addr(rom_addr), .rom_data(rom_data),
      .count_pulse(count_pulse), .latch_strobe(latch_strobe), .digits(digits),
      .port_c_lines(port_c_lines), .port_a_lines(port_a_lines), .buzzer(buzzer),
      .mux_digit(mux_digit), .mux_sel_n(mux_sel_n), .test_done(test_done)
   );
   lmds_panel_model i_panel (
      .sys_clk(sys_clk), .rom_addr(rom_addr), .rom_data(rom_data), .keys(keys),
      .alarms(alarms), .count_pulse(count_pulse), .latch_strobe(latch_strobe)
   );

   task automatic check(input string what, input logic [27:0] seen, input logic [27:0] exp);
      tests_run++;
      if (seen !== exp) begin
         n_fail++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic final_report();
      $display("comparisons %0d mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   task automatic cyc(input int n);
      repeat (n) @(negedge sys_clk);
   endtask

   // bounded wait for a masked display value; a timeout ends the run
   task automatic wait_dig(input logic [27:0] val, input logic [27:0] msk);
      for (int i = 0; i < 4000; i++) begin
         @(negedge sys_clk);
         if ((digits & msk) === val) return;
      end
      n_fail++;
      $display("Error display wait expected %h seen %h", val, digits);
      final_report();
   endtask

   // bounded wait for one digit select, then its decade; a timeout ends the run
   task automatic wait_mux(input logic [2:0] sel, input logic [3:0] exp);
      for (int i = 0; i < 300; i++) begin
         @(negedge sys_clk);
         if (mux_sel_n === sel) begin
            check("mux digit", {24'h0, mux_digit}, {24'h0, exp});
            return;
         end
      end
      n_fail++;
      $display("Error mux select expected %h seen %h", sel, mux_sel_n);
      final_report();
   endtask

   initial begin
      rst_n = 1'b0;
      ce = 1'b1;
      start = 1'b0;
      cyc(5);
      rst_n = 1'b1;
      // memory test, frozen at its end by hold
      i_panel.set_panel(11'h400, 6'h00);
      cyc(10);
      start = 1'b1;
      cyc(10);
      start = 1'b0;
      wait_dig(28'h3300000, 28'hff00000);
      cyc(100);
      check("memory g f", {20'h0, digits.g, digits.f}, 28'h33);
      $display("test memory done");
      // checksum test, held once running so the sums stay up
      i_panel.set_panel(11'h000, 6'h00);
      wait_dig(28'h4000000, 28'hf000000);
      i_panel.set_panel(11'h400, 6'h00);
      cyc(400);
      s1 = 8'h00;
      s2 = 8'h00;
      for (s = 0; s < 256; s++) begin
         if (s < 128) s1 = s1 + i_panel.rom_byte(8'(s));
         else s2 = s2 + i_panel.rom_byte(8'(s));
      end
      check("checksums", digits, {4'h4, 2'h0, s2[7:6], 1'b0, s2[5:3], 1'b0, s2[2:0],
         2'h0, s1[7:6], 1'b0, s1[5:3], 1'b0, s1[2:0]});
      $display("test checksum done");
      // input lines, every weight of every digit
      i_panel.set_panel(11'h000, 6'h00);
      wait_dig(28'h5000000, 28'hf000000);
      for (s = 0; s < 4; s++) begin
         i_panel.set_panel(key_tab[s], alm_tab[s]);
         cyc(200);
         check("input digits", digits, {4'h5, dig_tab[s]});
      end
      $display("test input done");
      // reset plus indicator check leaves the input test
      i_panel.set_panel(11'h280, 6'h00);
      wait_dig(28'h6000000, 28'hf000000);
      i_panel.set_panel(11'h000, 6'h00);
      for (s = 0; s < 13; s++) begin
         wait_dig({4'h6, 4'(s % 8), 4'(s / 8), 16'h0}, 28'hfff0000);
         cyc(3);
         ea = (s == 0) ? 8'hff : (s > 4) ? 8'(1 << (s - 5)) : 8'h00;
         ec = (s == 0) ? 3'h7 : (s > 1 && s < 5) ? 3'(1 << (s - 2)) : 3'h0;
         check("out lines", {17'h0, port_c_lines, port_a_lines}, {17'h0, ec, ea});
         check("buzzer", {27'h0, buzzer}, 28'(s == 0 || s == 10));
      end
      // last sub-test held, then released into the counter test
      i_panel.set_panel(11'h400, 6'h00);
      cyc(150);
      check("held sub", {16'h0, digits.g, digits.f, digits.e}, 28'h641);
      i_panel.set_panel(11'h000, 6'h00);
      wait_dig(28'h7000000, 28'hf000000);
      $display("test output done");
      // two count, latch and show rounds without leaving
      for (s = 0; s < 2; s++) begin
         i_panel.pulses(s ? 7 : 123);
         i_panel.strobe();
         i_panel.set_panel(11'h002, 6'h00);
         cyc(20);
         check("count", {8'h0, digits[27:8]}, {8'h0, 4'h7, s ? 16'h7000 : 16'h3210});
         check("done flag", {27'h0, test_done}, 28'h1);
         // upper three decades in turn, least significant select first
         for (int m = 0; m < 3; m++) begin
            wait_mux(3'(~(3'b001 << m)), s ? 4'h0 : 4'(2 - m));
         end
         i_panel.set_panel(11'h000, 6'h00);
      end
      // reset key ends the sequence after the counter test
      i_panel.set_panel(11'h200, 6'h00);
      cyc(20);
      check("done state", {23'h0, digits.g, test_done}, 28'h1);
      $display("test counter done");
      final_report();
   end
endmodule
`default_nettype wire
